// [logic/can_error_state_tracker.sv]
/*
 * Fault confinement tracker: transmit and receive fault tallies,
 * error-active / error-passive / bus-off mode, automatic bus-off
 * recovery and the fault status register, on a simple register port.
 * Assumes the protocol engine gives one-cycle event pulses on clk_i and
 * a bit tick with the sampled bus level; the host port is on clk_i.
 */
`timescale 1ns/10ps

// Function
// R1: both tallies under 128 means error-active
// R2: either tally at 128 or more: passive
// R3: outbound tally above 255 enters bus-off, bit 5
// R4: bus-off holds until 128 runs of 11 recessive
// R5: recovery returns to active unaided, clears flag
// R6: tallies readable at 1Ch and 1Dh, reset zero
// R7: tallies follow standard CAN confinement steps
// R8: any-warning flag while either tally reaches 96
// R9: outbound and inbound warning flags, bits 2,1
// R10: overflow flags set on full buffer, host clears
// R11: status register readable at 2Dh, resets zero
// R12: host wanting no auto-recovery handles it itself; here recovery is always automatic, with no host control
// R13: outbound and inbound passive flags, bits 4,3
// R14: bus-off node neither sends nor receives
module can_error_state_tracker (
   input  wire logic                     clk_i,
   input  wire logic                     sys_rst_i,
   // protocol engine events
   input  wire logic                     tx_error_i,
   input  wire logic                     tx_success_i,
   input  wire logic                     rx_error_i,
   input  wire logic                     rx_error_major_i,
   input  wire logic                     rx_success_i,
   input  wire logic                     bit_tick_i,
   input  wire logic                     bus_recessive_i,
   // receive buffer events
   input  wire logic                     buf0_msg_valid_i,
   input  wire logic                     buf1_msg_valid_i,
   input  wire logic                     buffer_zero_full_flag_i,
   input  wire logic                     buffer_one_full_flag_i,
   // host register port
   input  wire logic [7:0]               reg_addr_i,
   input  wire logic                     reg_rd_i,
   input  wire logic                     reg_wr_i,
   input  wire logic [7:0]               reg_wdata_i,
   output logic      [7:0]               reg_rdata_o,
   // mode towards the protocol engine
   output fault_confine_pkg::err_mode_t  err_mode_o,
   output logic                          node_enable_o
);
   import fault_confine_pkg::*;

   // =====================================================================
   // state
   err_mode_t   mode_q;
   err_mode_t   mode_d;
   logic [8:0]  tec_q;
   logic [8:0]  tec_d;
   logic [8:0]  rec_q;
   logic [8:0]  rec_d;
   logic        ovf_zero_q;
   logic        ovf_one_q;
   logic        recovered;
   logic        tx_warn;
   logic        rx_warn;
   logic        tx_pass;
   logic        rx_pass;
   logic [7:0]  status;
   logic        status_wr;

   // saturating add within 9 bits
   function automatic logic [8:0] sat_add(input logic [8:0] a,
                                          input logic [8:0] b);
      logic [9:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[9] ? 9'h1ff : s[8:0];
   endfunction

   // decrement that stops at zero
   function automatic logic [8:0] dec_floor(input logic [8:0] a);
      dec_floor = (a == 9'h000) ? 9'h000 : a - ERR_STEP_ONE;
   endfunction

   // =====================================================================
   // bus-off recovery sequence detector
   idle_run_counter #(
      .RUN_BITS  (RUN_BITS),
      .RUN_COUNT (RUN_COUNT)
   ) u_idle_runs (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .arm_i       (mode_q == BUS_OFF),
      .bit_tick_i  (bit_tick_i),
      .recessive_i (bus_recessive_i),
      .done_o      (recovered)
   );

   // =====================================================================
   // next tally values; errors take priority over a success in the
   // same cycle, since a frame cannot both fail and pass
   always_comb begin
      tec_d = tec_q;
      rec_d = rec_q;
      if (mode_q == BUS_OFF) begin
         // frozen while off the bus; cleared when the sequence completes
         if (recovered) begin
            tec_d = 9'h000;                                    // R5
            rec_d = 9'h000;                                    // R5
         end
      end else begin
         if (tx_error_i) begin
            tec_d = sat_add(tec_q, ERR_STEP_BIG);              // R7
         end else if (tx_success_i) begin
            tec_d = dec_floor(tec_q);                          // R7
         end
         if (rx_error_major_i) begin
            rec_d = sat_add(rec_q, ERR_STEP_BIG);              // R7
         end else if (rx_error_i) begin
            rec_d = sat_add(rec_q, ERR_STEP_ONE);              // R7
         end else if (rx_success_i) begin
            // a passive receiver drops back just under the limit
            rec_d = (rec_q >= PASSIVE_LIMIT) ? REC_RESTART
                                             : dec_floor(rec_q); // R7
         end
         // the inbound tally is shown in 8 bits; hold it at the top
         if (rec_d > BUS_OFF_LIMIT) begin
            rec_d = BUS_OFF_LIMIT;
         end
      end
   end

   // tally registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tec_q <= {1'b0, TALLY_RESET};                         // R6
         rec_q <= {1'b0, TALLY_RESET};                         // R6
      end else begin
         tec_q <= tec_d;
         rec_q <= rec_d;
      end
   end

   // =====================================================================
   // error mode, from the next tally values so mode and tallies agree
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         ERR_ACTIVE, ERR_PASSIVE: begin
            if (tec_d > BUS_OFF_LIMIT) begin
               mode_d = BUS_OFF;                               // R3 R14
            end else if (tec_d >= PASSIVE_LIMIT ||
                         rec_d >= PASSIVE_LIMIT) begin
               mode_d = ERR_PASSIVE;                           // R2
            end else begin
               mode_d = ERR_ACTIVE;                            // R1
            end
         end
         BUS_OFF: begin
            // no host action is needed to leave bus-off
            if (recovered) begin
               mode_d = ERR_ACTIVE;                            // R4 R5
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mode_q <= ERR_ACTIVE;
      end else begin
         mode_q <= mode_d;
      end
   end

   assign err_mode_o    = mode_q;
   assign node_enable_o = (mode_q != BUS_OFF);                 // R14

   // =====================================================================
   // overflow flags; a new overflow in the clearing cycle wins
   assign status_wr = reg_wr_i && (reg_addr_i == STATUS_ADDR);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ovf_zero_q <= STATUS_RESET[OVF_ZERO_BIT];
         ovf_one_q  <= STATUS_RESET[OVF_ONE_BIT];
      end else begin
         if (buf0_msg_valid_i && buffer_zero_full_flag_i) begin
            ovf_zero_q <= 1'b1;                                // R10
         end else if (status_wr && !reg_wdata_i[OVF_ZERO_BIT]) begin
            ovf_zero_q <= 1'b0;                                // R10
         end
         if (buf1_msg_valid_i && buffer_one_full_flag_i) begin
            ovf_one_q <= 1'b1;                                 // R10
         end else if (status_wr && !reg_wdata_i[OVF_ONE_BIT]) begin
            ovf_one_q <= 1'b0;                                 // R10
         end
      end
   end

   // =====================================================================
   // live status flags derived from the tallies
   assign tx_warn = (tec_q >= WARN_LIMIT);                     // R9
   assign rx_warn = (rec_q >= WARN_LIMIT);                     // R9
   assign tx_pass = (tec_q >= PASSIVE_LIMIT);                  // R13
   assign rx_pass = (rec_q >= PASSIVE_LIMIT);                  // R13

   always_comb begin
      status               = STATUS_RESET;
      status[ANY_WARN_BIT] = tx_warn || rx_warn;               // R8
      status[RX_WARN_BIT]  = rx_warn;
      status[TX_WARN_BIT]  = tx_warn;
      status[RX_PASS_BIT]  = rx_pass;
      status[TX_PASS_BIT]  = tx_pass;
      status[BUS_OFF_BIT]  = (mode_q == BUS_OFF);              // R3
      status[OVF_ZERO_BIT] = ovf_zero_q;
      status[OVF_ONE_BIT]  = ovf_one_q;
   end

   // =====================================================================
   // read port: data one cycle after the strobe, held until next read
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= UNMAPPED_VAL;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            TEC_ADDR:    reg_rdata_o <= tec_q[7:0];            // R6
            REC_ADDR:    reg_rdata_o <= rec_q[7:0];            // R6
            STATUS_ADDR: reg_rdata_o <= status;                // R11
            default:     reg_rdata_o <= UNMAPPED_VAL;
         endcase
      end
   end

   // =====================================================================
   // checks
   active_mode_a: assert property (@(posedge clk_i) // R1
      disable iff (sys_rst_i)
      (mode_q != BUS_OFF && tec_q < PASSIVE_LIMIT && rec_q < PASSIVE_LIMIT)
      |-> mode_q == ERR_ACTIVE)
      else $error("node not error-active with low tallies");

   passive_mode_a: assert property (@(posedge clk_i) // R2
      disable iff (sys_rst_i)
      (mode_q != BUS_OFF && (tec_q >= PASSIVE_LIMIT || rec_q >= PASSIVE_LIMIT))
      |-> mode_q == ERR_PASSIVE)
      else $error("node not error-passive with a high tally");

   bus_off_entry_a: assert property (@(posedge clk_i) // R3
      disable iff (sys_rst_i)
      (mode_q != BUS_OFF && tx_error_i && tec_q > 9'h0f7)
      |=> mode_q == BUS_OFF && status[BUS_OFF_BIT])
      else $error("outbound overflow did not enter bus-off");

   bus_off_hold_a: assert property (@(posedge clk_i) // R4
      disable iff (sys_rst_i)
      (mode_q == BUS_OFF && !recovered) |=> mode_q == BUS_OFF)
      else $error("bus-off left before the recovery sequence");

   recovery_exit_a: assert property (@(posedge clk_i) // R5
      disable iff (sys_rst_i)
      (mode_q == BUS_OFF && recovered)
      |=> mode_q == ERR_ACTIVE && tec_q == 9'h000 && !status[BUS_OFF_BIT])
      else $error("recovery did not return to error-active");

   tally_read_a: assert property (@(posedge clk_i) // R6
      disable iff (sys_rst_i)
      (reg_rd_i && reg_addr_i == TEC_ADDR)
      |=> reg_rdata_o == $past(tec_q[7:0]))
      else $error("outbound tally read returned wrong value");

   tx_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
      (mode_q != BUS_OFF && tx_error_i && tec_q < 9'h0f8)
      |=> tec_q == $past(tec_q) + ERR_STEP_BIG)
      else $error("outbound tally did not step by eight");

   rx_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
      (mode_q != BUS_OFF && rx_error_i && !rx_error_major_i && rec_q < 9'h0ff)
      |=> rec_q == $past(rec_q) + ERR_STEP_ONE)
      else $error("inbound tally did not step by one");

   warn_flag_a: assert property (@(posedge clk_i) // R8
      disable iff (sys_rst_i)
      (mode_q != BUS_OFF && tx_error_i && tec_q >= WARN_LIMIT - ERR_STEP_BIG)
      |=> status[ANY_WARN_BIT])
      else $error("any-warning flag wrong");

   warn_split_a: assert property (@(posedge clk_i) // R9
      disable iff (sys_rst_i)
      (mode_q != BUS_OFF && rx_error_major_i &&
       rec_q >= WARN_LIMIT - ERR_STEP_BIG)
      |=> status[RX_WARN_BIT] && status[ANY_WARN_BIT])
      else $error("inbound warning flags not raised");

   overflow_set_a: assert property (@(posedge clk_i) // R10
      disable iff (sys_rst_i)
      (buf1_msg_valid_i && buffer_one_full_flag_i) |=> status[OVF_ONE_BIT])
      else $error("buffer one overflow not flagged");

   status_read_a: assert property (@(posedge clk_i) // R11
      disable iff (sys_rst_i)
      (reg_rd_i && reg_addr_i == STATUS_ADDR)
      |=> reg_rdata_o == $past(status))
      else $error("status read returned wrong value");

   passive_flag_a: assert property (@(posedge clk_i) // R13
      disable iff (sys_rst_i)
      (mode_q != BUS_OFF && rx_error_major_i &&
       rec_q >= PASSIVE_LIMIT - ERR_STEP_BIG) |=> status[RX_PASS_BIT])
      else $error("inbound passive flag not raised");

   silent_off_a: assert property (@(posedge clk_i) // R14
      disable iff (sys_rst_i)
      (mode_q == BUS_OFF && !recovered)
      |=> !node_enable_o && $stable(tec_q) && $stable(rec_q))
      else $error("bus-off node still active");

endmodule

// [logic/fault_confine_pkg.sv]
/*
 * Constants and types shared by the fault confinement tracker:
 * register addresses, status bit positions, reset values, limits.
 * Assumes an 8-bit register address space and one 50 MHz clock.
 */
package fault_confine_pkg;

   // =====================================================================
   // register addresses
   localparam logic [7:0] TEC_ADDR    = 8'h1c;
   localparam logic [7:0] REC_ADDR    = 8'h1d;
   localparam logic [7:0] STATUS_ADDR = 8'h2d;

   // =====================================================================
   // fault status register bit positions
   localparam int ANY_WARN_BIT  = 0;
   localparam int RX_WARN_BIT   = 1;
   localparam int TX_WARN_BIT   = 2;
   localparam int RX_PASS_BIT   = 3;
   localparam int TX_PASS_BIT   = 4;
   localparam int BUS_OFF_BIT   = 5;
   localparam int OVF_ZERO_BIT  = 6;
   localparam int OVF_ONE_BIT   = 7;

   // =====================================================================
   // reset values
   localparam logic [7:0] TALLY_RESET  = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;

   // =====================================================================
   // tally limits and steps
   localparam logic [8:0] WARN_LIMIT    = 9'h060;   // 96
   localparam logic [8:0] PASSIVE_LIMIT = 9'h080;   // 128
   localparam logic [8:0] BUS_OFF_LIMIT = 9'h0ff;   // 255
   localparam logic [8:0] ERR_STEP_BIG  = 9'h008;   // +8 events
   localparam logic [8:0] ERR_STEP_ONE  = 9'h001;   // +1 / -1 events
   localparam logic [8:0] REC_RESTART   = 9'h078;   // 120, in 119..127

   // =====================================================================
   // bus-off recovery sequence
   localparam int RUN_BITS  = 11;    // recessive bits per idle run
   localparam int RUN_COUNT = 128;   // idle runs needed

   // error mode of the node
   typedef enum logic [1:0] {
      ERR_ACTIVE,
      ERR_PASSIVE,
      BUS_OFF
   } err_mode_t;

endpackage

// [logic/idle_run_counter.sv]
/*
 * Counts runs of consecutive recessive bits while the node is bus-off
 * and pulses done_o when enough runs have been seen.
 * Assumes bit_tick_i is a one-cycle enable per sampled bus bit and
 * recessive_i is the sampled level, both from logic on clk_i.
 */
`timescale 1ns/10ps
module idle_run_counter #(
   parameter int RUN_BITS  = fault_confine_pkg::RUN_BITS,
   parameter int RUN_COUNT = fault_confine_pkg::RUN_COUNT
) (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic arm_i,
   input  wire logic bit_tick_i,
   input  wire logic recessive_i,
   output logic      done_o
);
   import fault_confine_pkg::*;

   localparam int BW = $clog2(RUN_BITS + 1);
   localparam int RW = $clog2(RUN_COUNT + 1);
   localparam logic [BW-1:0] BITS_LAST = BW'(RUN_BITS - 1);
   localparam logic [RW-1:0] RUNS_LAST = RW'(RUN_COUNT - 1);

   logic [BW-1:0] bit_cnt_q;
   logic [RW-1:0] run_cnt_q;
   logic          run_end;

   assign run_end = bit_tick_i && recessive_i && (bit_cnt_q == BITS_LAST);

   // =====================================================================
   // recessive bit run length; a dominant bit restarts the run
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !arm_i) begin
         bit_cnt_q <= '0;
      end else if (bit_tick_i) begin
         if (!recessive_i || run_end) begin
            bit_cnt_q <= '0;                                   // R4
         end else begin
            bit_cnt_q <= bit_cnt_q + BW'(1);
         end
      end
   end

   // number of completed idle runs; done pulses on the last one
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !arm_i) begin
         run_cnt_q <= '0;
         done_o    <= 1'b0;
      end else begin
         done_o <= run_end && (run_cnt_q == RUNS_LAST);       // R4
         if (run_end) begin
            run_cnt_q <= (run_cnt_q == RUNS_LAST) ? '0 : run_cnt_q + RW'(1);
         end
      end
   end

   // done only follows the closing bit of the last run
   run_done_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R4
      done_o |-> $past(run_cnt_q) == RUNS_LAST && $past(bit_tick_i))
      else $error("recovery done without a full idle sequence");

endmodule

// [verification/can_bus_peer.sv]
/*
 * Model of the other nodes on the shared CAN bus: one sampled bit tick
 * per bit time and the bus level, either busy frames or an idle bus.
 * Assumes one clk_i domain; glitch_at_i of 0 means an undisturbed idle.
 */
`timescale 1ns/10ps
module can_bus_peer #(
   parameter int BIT_DIV = 3
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        idle_i,
   input  wire logic [15:0] glitch_at_i,
   output logic             bit_tick_o,
   output logic             recessive_o
);
   // ====================
   // bit timing
   logic [3:0]  div_q;
   logic [2:0]  frm_q;
   logic [15:0] idle_cnt_q;

   // one tick per bit time, from a free-running divider
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         div_q      <= 4'h0;
         bit_tick_o <= 1'b0;
      end else begin
         bit_tick_o <= (div_q == 4'(BIT_DIV - 1));
         div_q      <= (div_q == 4'(BIT_DIV - 1)) ? 4'h0 : div_q + 4'h1;
      end
   end

   // busy frames hold a dominant bit every fifth bit, as stuffing would,
   // so an idle run can only be seen while the bus is really idle
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         frm_q       <= 3'h0;
         idle_cnt_q  <= 16'h0000;
         recessive_o <= 1'b1;
      end else if (div_q == 4'(BIT_DIV - 1)) begin
         frm_q      <= (frm_q == 3'h4) ? 3'h0 : frm_q + 3'h1;
         idle_cnt_q <= idle_i ? idle_cnt_q + 16'h0001 : 16'h0000;
         if (idle_i) begin
            recessive_o <= (idle_cnt_q + 16'h0001 != glitch_at_i);
         end else begin
            recessive_o <= (frm_q != 3'h0);
         end
      end
   end
endmodule

// [verification/tb_top.sv]
/*
 * Self-checking bench of the fault confinement tracker: random and
 * hand-made event streams, bus-off entry and recovery, overflow flags.
 * Assumes the bus peer model and the fault_confine_pkg package.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; \
   if ((got) !== (ex)) begin num_errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_top;
   import fault_confine_pkg::*;
   // ====================
   // signals and bench state
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        tx_err, tx_ok, rx_err, rx_maj, rx_ok;
   logic        bit_tick, bus_rec, buf0_v, buf1_v, full0, full1;
   logic [7:0]  addr, wdata, rdata;
   logic        rd, wr, node_en, watch, idle;
   logic [15:0] glitch_at;
   err_mode_t   mode;
   logic [8:0]  tec_e, rec_e;
   integer      seed = 32'h0356;
   int          samples_checked, num_errors, runs, run_len, cycles;

   always #10 clk_i = ~clk_i;

   can_bus_peer peer (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .idle_i(idle), .glitch_at_i(glitch_at), .bit_tick_o(bit_tick),
      .recessive_o(bus_rec));
   can_error_state_tracker dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .tx_error_i(tx_err), .tx_success_i(tx_ok), .rx_error_i(rx_err),
      .rx_error_major_i(rx_maj), .rx_success_i(rx_ok),
      .bit_tick_i(bit_tick), .bus_recessive_i(bus_rec),
      .buf0_msg_valid_i(buf0_v), .buf1_msg_valid_i(buf1_v),
      .buffer_zero_full_flag_i(full0), .buffer_one_full_flag_i(full1),
      .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .err_mode_o(mode),
      .node_enable_o(node_en));

   // ====================
   // expectations
   function automatic logic [8:0] nxt_tec(logic [8:0] t, logic e, logic s);
      return e ? t + 9'h008 : (s && t != 9'h000) ? t - 9'h001 : t;
   endfunction
   function automatic logic [8:0] nxt_rec(logic [8:0] r, logic e,
                                          logic m, logic s);
      if (m) return (r > 9'h0f7) ? 9'h0ff : r + 9'h008;
      if (e) return (r == 9'h0ff) ? r : r + 9'h001;
      if (s) return (r >= 9'h080) ? 9'h078 : (r != 0) ? r - 9'h001 : r;
      return r;
   endfunction
   function automatic logic [7:0] st_exp(logic [8:0] t, logic [8:0] r);
      logic [7:0] s;
      s = 8'h00;
      s[4] = t >= 9'h080;
      s[3] = r >= 9'h080;
      s[2] = t >= 9'h060;
      s[1] = r >= 9'h060;
      s[0] = s[2] | s[1];
      return s;
   endfunction
   function automatic err_mode_t mode_exp(logic [8:0] t, logic [8:0] r);
      return (t >= 9'h080 || r >= 9'h080) ? ERR_PASSIVE : ERR_ACTIVE;
   endfunction

   // ====================
   // drivers; each leaves its strobes low one edge after raising them
   task automatic ev(input logic [4:0] e);
      @(posedge clk_i);
      #1 {tx_err, tx_ok, rx_err, rx_maj, rx_ok} = e;
      @(posedge clk_i);
      #1 {tx_err, tx_ok, rx_err, rx_maj, rx_ok} = 5'h00;
      if (tec_e <= 9'h0ff) begin // events are refused once bus-off
         tec_e = nxt_tec(tec_e, e[4], e[3]);
         rec_e = nxt_rec(rec_e, e[2], e[1], e[0]);
      end
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #1 addr = a;
      rd = 1'b1;
      @(posedge clk_i);
      #1 rd = 1'b0;
      d = rdata;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1 addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk_i);
      #1 wr = 1'b0;
   endtask
   task automatic chk_all;
      logic [7:0] d;
      rd_reg(TEC_ADDR, d);
      `CHK("outbound tally", tec_e[7:0], d)
      rd_reg(REC_ADDR, d);
      `CHK("inbound tally", rec_e[7:0], d)
      rd_reg(STATUS_ADDR, d);
      `CHK("status", st_exp(tec_e, rec_e), d)
      `CHK("mode", mode_exp(tec_e, rec_e), mode)
      `CHK("node enable", 1'b1, node_en)
   endtask
   // overflow step: buffer events, an optional status write, then a read
   task automatic ovf_step(input logic [1:0] v, input logic [1:0] f,
                           input logic w, input logic [7:0] wd,
                           input logic [7:0] ex);
      logic [7:0] d;
      @(posedge clk_i);
      #1 {buf1_v, buf0_v} = v;
      {full1, full0} = f;
      {wr, addr, wdata} = {w, STATUS_ADDR, wd};
      @(posedge clk_i);
      #1 {buf1_v, buf0_v, wr} = 3'b000;
      rd_reg(STATUS_ADDR, d);
      `CHK("overflow flags", ex, d)
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ====================
   // recovery run counter: a dominant bit restarts only the current run
   always @(posedge clk_i) begin
      if (watch && bit_tick) begin
         if (!bus_rec) run_len <= 0;
         else if (run_len == 10) begin
            run_len <= 0;
            runs    <= runs + 1;
         end else run_len <= run_len + 1;
      end
   end

   // hang guard, well above the roughly 5200 cycles the run needs
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end

   // ====================
   // main sequence
   initial begin
      logic [7:0] d;
      logic [4:0] e;
      {tx_err, tx_ok, rx_err, rx_maj, rx_ok, rd, wr} = 7'h00;
      {buf0_v, buf1_v, full0, full1, watch, idle} = 6'h00;
      {addr, wdata, glitch_at} = {8'h00, 8'h00, 16'h02c5};
      {tec_e, rec_e, runs, run_len, cycles} = '0;
      repeat (12) @(posedge clk_i);
      #1 sys_rst_i = 1'b0;
      chk_all();
      rd_reg(8'h3f, d);
      `CHK("unmapped read", 8'h00, d)
      for (int i = 1; i <= 12; i++) begin // warning edge at 88 and 96
         ev(5'h10);
         if (i >= 11) chk_all();
      end
      ev(5'h08); // back to 95: warnings drop
      wr_reg(TEC_ADDR, 8'h00); // tallies are read-only
      wr_reg(REC_ADDR, 8'h55);
      wr_reg(STATUS_ADDR, 8'hff);
      chk_all();
      repeat (16) ev(5'h02); // inbound to exactly 128
      chk_all();
      ev(5'h01); // success from passive restarts the inbound tally
      chk_all();
      $display("test thresholds done");
      repeat (80) begin
         e = 5'($random(seed));
         if (tec_e > 9'h0b0) e[4] = 1'b0; // stay clear of bus-off here
         ev(e);
         chk_all();
      end
      $display("test random events done");
      while (tec_e <= 9'h0ff) begin
         ev(5'h10);
         if (tec_e <= 9'h0ff) chk_all();
      end
      `CHK("mode", BUS_OFF, mode)
      `CHK("node enable", 1'b0, node_en)
      rd_reg(STATUS_ADDR, d);
      `CHK("bus-off flag", 1'b1, d[BUS_OFF_BIT])
      ev(5'h06); // receive faults are ignored while bus-off
      rd_reg(REC_ADDR, d);
      `CHK("frozen inbound", rec_e[7:0], d)
      watch = 1'b1;
      do begin // align the run count on a dominant bit
         @(posedge clk_i);
         #1;
      end while (!(bit_tick && !bus_rec));
      idle = 1'b1;
      while (runs < 128) begin
         @(posedge clk_i);
         #1;
      end
      // last run just sampled: done is internal, mode moves one edge later
      `CHK("mode", BUS_OFF, mode)
      @(posedge clk_i);
      #1 `CHK("mode", ERR_ACTIVE, mode)
      {tec_e, rec_e} = 18'h00000;
      chk_all(); // tallies and bus-off flag cleared by recovery
      $display("test bus-off recovery done");
      ovf_step(2'b01, 2'b00, 1'b0, 8'h00, 8'h00);
      ovf_step(2'b01, 2'b01, 1'b0, 8'h00, 8'h40);
      ovf_step(2'b10, 2'b11, 1'b0, 8'h00, 8'hc0);
      ovf_step(2'b00, 2'b11, 1'b1, 8'hff, 8'hc0);
      ovf_step(2'b00, 2'b00, 1'b1, 8'h40, 8'h40);
      ovf_step(2'b01, 2'b01, 1'b1, 8'h00, 8'h40);
      ovf_step(2'b00, 2'b00, 1'b1, 8'h00, 8'h00);
      $display("test overflow flags done");
      print_verdict();
   end
endmodule
